/* File: rtl/nlar_noload_regs.sv */
`timescale 1ns/10ps
module nlar_noload_regs
  import nlar_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [15:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire nlar_noload_t noload_in,
  input wire nlar_adc_set_t adc_in,
  input wire logic adc_valid_in,
  output logic [23:0] volt_b_data_out,
  output logic [23:0] volt_c_data_out,
  output logic volt_data_valid_out,
  output logic [23:0] fund_var_level_out,
  output logic irq_out
);
  logic [23:0] level_reg;
  logic [2:0] vb_sel_reg;
  logic [2:0] vc_sel_reg;
  nlar_noload_t noload_reg;
  logic [31:0] prdata_reg;
  logic [31:0] irq_status;
  logic [31:0] irq_mask;

  // bus phases; zero wait states, so pready follows the access phase
  wire logic setup_ph = psel_in & ~penable_in;
  wire logic access_ph = psel_in & penable_in;

  wire logic hit_level = paddr_in == ADDR_LEVEL;
  wire logic hit_noload = paddr_in == ADDR_NOLOAD;
  wire logic hit_route = paddr_in == ADDR_ROUTE;
  wire logic hit_status = paddr_in == ADDR_IRQ_STATUS;
  wire logic hit_mask = paddr_in == ADDR_IRQ_MASK;
  wire logic mapped = hit_level | hit_noload | hit_route | hit_status | hit_mask;

  wire logic wr_ph = access_ph & pwrite_in;
  wire logic wr_level = wr_ph & hit_level;
  wire logic wr_route = wr_ph & hit_route;
  wire logic wr_status = wr_ph & hit_status;
  wire logic wr_mask = wr_ph & hit_mask;

  wire logic [31:0] level_word = {{(DATA_W - LEVEL_W){1'b0}}, level_reg};
  wire logic [31:0] route_word = nlar_route_word(vb_sel_reg, vc_sel_reg);
  wire logic [31:0] noload_word = nlar_noload_word(noload_reg);

  // reserved bits are masked off on the way in, so they cannot store
  wire logic [31:0] level_merged = nlar_merge(level_word, pwdata_in, pstrb_in) & LEVEL_IMPL;
  wire logic [31:0] route_merged = nlar_merge(route_word, pwdata_in, pstrb_in) & ROUTE_IMPL;
  wire logic [31:0] mask_merged = nlar_merge(irq_mask, pwdata_in, pstrb_in);
  wire logic [31:0] clear_word = wr_status ? nlar_merge('0, pwdata_in, pstrb_in) : '0;

  wire logic [23:0] level_next = wr_level ? level_merged[LEVEL_W-1:0] : level_reg;
  wire logic [2:0] vc_sel_next = wr_route ? route_merged[VC_LSB +: SEL_W] : vc_sel_reg;
  wire logic [2:0] vb_sel_next = wr_route ? route_merged[VB_LSB +: SEL_W] : vb_sel_reg;

  // read word; the no-load word is laid out per phase by a shared function
  wire logic [31:0] rd_word =
    hit_level ? level_word :
    hit_noload ? (noload_word & NOLOAD_IMPL) :
    hit_route ? route_word :
    hit_status ? irq_status :
    hit_mask ? irq_mask : '0;
  wire logic [31:0] prdata_next = setup_ph ? (pwrite_in ? '0 : rd_word) : prdata_reg;

  // a change of any phase in a category is one event for that category
  wire logic ev_act = |(noload_in.active ^ noload_reg.active);
  wire logic ev_react = |(noload_in.reactive ^ noload_reg.reactive);
  wire logic ev_app = |(noload_in.apparent ^ noload_reg.apparent);
  wire logic ev_fund = |(noload_in.fund_reactive ^ noload_reg.fund_reactive);
  logic [31:0] event_word;
  always_comb begin
    event_word = '0;
    event_word[IRQ_ACT] = ev_act;
    event_word[IRQ_REACT] = ev_react;
    event_word[IRQ_APP] = ev_app;
    event_word[IRQ_FUND] = ev_fund;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      level_reg <= LEVEL_RESET;
      vb_sel_reg <= ROUTE_RESET;
      vc_sel_reg <= ROUTE_RESET;
      noload_reg <= '0;
      prdata_reg <= '0;
    end else begin
      level_reg <= level_next;
      vb_sel_reg <= vb_sel_next;
      vc_sel_reg <= vc_sel_next;
      noload_reg <= noload_in;
      prdata_reg <= prdata_next;
    end
  end

  nlar_irq u_irq (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .event_in(event_word),
    .clear_in(clear_word),
    .mask_we_in(wr_mask),
    .mask_in(mask_merged),
    .status_out(irq_status),
    .mask_out(irq_mask),
    .irq_out(irq_out)
  );

  // each voltage channel has its own mux; own code 111 selects its own adc
  nlar_route_mux u_vc_mux (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .code_in(vc_sel_reg),
    .adc_in(adc_in),
    .own_in(adc_in.vc),
    .valid_in(adc_valid_in),
    .data_out(volt_c_data_out),
    .valid_out()
  );

  nlar_route_mux u_vb_mux (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .code_in(vb_sel_reg),
    .adc_in(adc_in),
    .own_in(adc_in.vb),
    .valid_in(adc_valid_in),
    .data_out(volt_b_data_out),
    .valid_out(volt_data_valid_out)
  );

  assign prdata_out = prdata_reg;
  assign pready_out = access_ph;
  // unmapped addresses complete with an error rather than hang the bus
  assign pslverr_out = access_ph & ~mapped;
  assign fund_var_level_out = level_reg;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  wire logic rd_access = access_ph & ~pwrite_in;

  level_read_a: assert property (
    rd_access & hit_level |-> prdata_out == level_word)
    else $error("level register read mismatch");

  level_write_a: assert property (
    wr_level & (pstrb_in == 4'hF) |=> fund_var_level_out == $past(pwdata_in[LEVEL_W-1:0]))
    else $error("level register write not stored");

  active_nl_a: assert property (
    rd_access & hit_noload |-> prdata_out[NL_ACT_BIT] == $past(noload_reg.active[0]) &&
      prdata_out[NL_ACT_BIT + NL_STRIDE] == $past(noload_reg.active[1]) &&
      prdata_out[NL_ACT_BIT + 2 * NL_STRIDE] == $past(noload_reg.active[2]))
    else $error("active no-load bits wrong");

  reactive_nl_a: assert property (
    rd_access & hit_noload |-> prdata_out[NL_REACT_BIT] == $past(noload_reg.reactive[0]) &&
      prdata_out[NL_REACT_BIT + NL_STRIDE] == $past(noload_reg.reactive[1]) &&
      prdata_out[NL_REACT_BIT + 2 * NL_STRIDE] == $past(noload_reg.reactive[2]))
    else $error("reactive no-load bits wrong");

  apparent_nl_a: assert property (
    rd_access & hit_noload |-> prdata_out[NL_APP_BIT] == $past(noload_reg.apparent[0]) &&
      prdata_out[NL_APP_BIT + NL_STRIDE] == $past(noload_reg.apparent[1]) &&
      prdata_out[NL_APP_BIT + 2 * NL_STRIDE] == $past(noload_reg.apparent[2]))
    else $error("apparent no-load bits wrong");

  fund_nl_a: assert property (
    rd_access & hit_noload |-> prdata_out[NL_FUND_BIT] == $past(noload_reg.fund_reactive[0]) &&
      prdata_out[NL_FUND_BIT + NL_STRIDE] == $past(noload_reg.fund_reactive[1]) &&
      prdata_out[NL_FUND_BIT + 2 * NL_STRIDE] == $past(noload_reg.fund_reactive[2]))
    else $error("fundamental no-load bits wrong");

  vc_own_a: assert property (
    adc_valid_in & (vc_sel_reg == SRC_OWN) |=> volt_c_data_out == $past(adc_in.vc))
    else $error("voltage c own source wrong");

  vc_from_ia_a: assert property (
    adc_valid_in & (vc_sel_reg == SRC_IA) |=> volt_c_data_out == $past(adc_in.ia))
    else $error("voltage c current a source wrong");

  vb_route_a: assert property (
    adc_valid_in & (vb_sel_reg == SRC_VA) |=> volt_b_data_out == $past(adc_in.va))
    else $error("voltage b voltage a source wrong");

  vb_own_a: assert property (
    adc_valid_in & (vb_sel_reg == SRC_OWN) |=> volt_b_data_out == $past(adc_in.vb))
    else $error("voltage b own source wrong");

  active_event_a: assert property (
    ev_act |=> irq_status[IRQ_ACT])
    else $error("active no-load change not latched");

  irq_level_a: assert property (
    irq_out == |(irq_status & irq_mask))
    else $error("interrupt output disagrees with status and mask");

  rsvd_zero_a: assert property (
    rd_access & (hit_route | hit_noload | hit_level) |->
      (prdata_out & ~(hit_route ? ROUTE_IMPL : hit_noload ? NOLOAD_IMPL : LEVEL_IMPL)) == '0)
    else $error("reserved bits read nonzero");

  unmapped_err_a: assert property (
    access_ph & ~mapped |-> pslverr_out & (prdata_out == '0))
    else $error("unmapped access not flagged");

  mapped_ok_a: assert property (
    access_ph & mapped |-> ~pslverr_out)
    else $error("mapped access flagged as error");

  setup_quiet_a: assert property (
    setup_ph |-> ~pready_out & ~pslverr_out)
    else $error("ready or error raised in setup cycle");

  // read data must not move under the master between setup and access
  rdata_hold_a: assert property (
    ~setup_ph |=> $stable(prdata_out))
    else $error("read data changed outside setup");

  level_hold_a: assert property (
    ~wr_level |=> $stable(fund_var_level_out))
    else $error("level changed without a write");

  noload_copy_a: assert property (
    1'b1 |=> noload_reg == $past(noload_in))
    else $error("no-load copy lags or leads its input");

  react_event_a: assert property (
    ev_react |=> irq_status[IRQ_REACT])
    else $error("reactive no-load change not latched");

  app_event_a: assert property (
    ev_app |=> irq_status[IRQ_APP])
    else $error("apparent no-load change not latched");

  fund_event_a: assert property (
    ev_fund |=> irq_status[IRQ_FUND])
    else $error("fundamental no-load change not latched");

  status_clear_a: assert property (
    clear_word[IRQ_ACT] & ~ev_act |=> ~irq_status[IRQ_ACT])
    else $error("status bit not cleared by a one");

  status_sticky_a: assert property (
    irq_status[IRQ_ACT] & ~clear_word[IRQ_ACT] |=> irq_status[IRQ_ACT])
    else $error("status bit lost without a clear");

  status_quiet_a: assert property (
    ~(|event_word) & ~wr_status |=> $stable(irq_status))
    else $error("status changed with no event or clear");

  mask_write_a: assert property (
    wr_mask & (pstrb_in == 4'hF) |=> irq_mask == ($past(pwdata_in) & IRQ_IMPL))
    else $error("mask write not stored");

  route_hold_a: assert property (
    ~wr_route |=> $stable(vc_sel_reg) && $stable(vb_sel_reg))
    else $error("route select changed without a write");

  vc_write_a: assert property (
    wr_route & (pstrb_in == 4'hF) |=> vc_sel_reg == $past(pwdata_in[VC_LSB +: SEL_W]))
    else $error("voltage c select not stored");

  vb_write_a: assert property (
    wr_route & (pstrb_in == 4'hF) |=> vb_sel_reg == $past(pwdata_in[VB_LSB +: SEL_W]))
    else $error("voltage b select not stored");

  valid_delay_a: assert property (
    1'b1 |=> volt_data_valid_out == $past(adc_valid_in))
    else $error("sample valid not one cycle behind strobe");

  // samples stand between strobes; downstream may read them late
  sample_hold_a: assert property (
    ~adc_valid_in |=> $stable(volt_c_data_out) && $stable(volt_b_data_out))
    else $error("routed sample changed without a strobe");

  // one arm of each mux per code, so a swapped arm cannot hide
  vc_from_ib_a: assert property (
    adc_valid_in & (vc_sel_reg == SRC_IB) |=> volt_c_data_out == $past(adc_in.ib))
    else $error("voltage c current b source wrong");

  vc_from_ic_a: assert property (
    adc_valid_in & (vc_sel_reg == SRC_IC) |=> volt_c_data_out == $past(adc_in.ic))
    else $error("voltage c current c source wrong");

  vc_from_in_a: assert property (
    adc_valid_in & (vc_sel_reg == SRC_IN) |=> volt_c_data_out == $past(adc_in.in_n))
    else $error("voltage c neutral source wrong");

  vc_from_va_a: assert property (
    adc_valid_in & (vc_sel_reg == SRC_VA) |=> volt_c_data_out == $past(adc_in.va))
    else $error("voltage c voltage a source wrong");

  vc_from_vb_a: assert property (
    adc_valid_in & (vc_sel_reg == SRC_VB) |=> volt_c_data_out == $past(adc_in.vb))
    else $error("voltage c voltage b source wrong");

  vc_from_vc_a: assert property (
    adc_valid_in & (vc_sel_reg == SRC_VC) |=> volt_c_data_out == $past(adc_in.vc))
    else $error("voltage c voltage c source wrong");

  vb_from_ia_a: assert property (
    adc_valid_in & (vb_sel_reg == SRC_IA) |=> volt_b_data_out == $past(adc_in.ia))
    else $error("voltage b current a source wrong");

  vb_from_ib_a: assert property (
    adc_valid_in & (vb_sel_reg == SRC_IB) |=> volt_b_data_out == $past(adc_in.ib))
    else $error("voltage b current b source wrong");

  vb_from_ic_a: assert property (
    adc_valid_in & (vb_sel_reg == SRC_IC) |=> volt_b_data_out == $past(adc_in.ic))
    else $error("voltage b current c source wrong");

  vb_from_in_a: assert property (
    adc_valid_in & (vb_sel_reg == SRC_IN) |=> volt_b_data_out == $past(adc_in.in_n))
    else $error("voltage b neutral source wrong");

  vb_from_vb_a: assert property (
    adc_valid_in & (vb_sel_reg == SRC_VB) |=> volt_b_data_out == $past(adc_in.vb))
    else $error("voltage b voltage b source wrong");

  vb_from_vc_a: assert property (
    adc_valid_in & (vb_sel_reg == SRC_VC) |=> volt_b_data_out == $past(adc_in.vc))
    else $error("voltage b voltage c source wrong");
endmodule

/* File: rtl/nlar_pkg.sv */
package nlar_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int SAMPLE_W = 24;
  localparam int LEVEL_W = 24;
  localparam int BYTE_W = 8;
  localparam int BYTES = 4;
  localparam int SEL_W = 3;
  localparam int PHASES = 3;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_LEVEL = 12'h40F;
  localparam logic [11:0] IDX_NOLOAD = 12'h41F;
  localparam logic [11:0] IDX_ROUTE = 12'h424;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h430;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h431;
  localparam logic [1:0] WORD_ALIGN = 2'h0;
  localparam logic [15:0] ADDR_LEVEL = {2'h0, IDX_LEVEL, WORD_ALIGN};
  localparam logic [15:0] ADDR_NOLOAD = {2'h0, IDX_NOLOAD, WORD_ALIGN};
  localparam logic [15:0] ADDR_ROUTE = {2'h0, IDX_ROUTE, WORD_ALIGN};
  localparam logic [15:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, WORD_ALIGN};
  localparam logic [15:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, WORD_ALIGN};

  localparam logic [23:0] LEVEL_RESET = 24'h45D45;
  localparam logic [2:0] ROUTE_RESET = 3'h7;
  localparam int VC_LSB = 18;
  localparam int VB_LSB = 15;

  // implemented bits of each register; all others read zero
  localparam logic [31:0] LEVEL_IMPL = 32'h00FFFFFF;
  localparam logic [31:0] NOLOAD_IMPL = 32'h000175D7;
  localparam logic [31:0] ROUTE_IMPL = 32'h001F8000;
  localparam logic [31:0] IRQ_IMPL = 32'h00000017;

  // no-load bit positions for phase a; phases b and c follow by stride
  localparam int NL_ACT_BIT = 0;
  localparam int NL_REACT_BIT = 1;
  localparam int NL_APP_BIT = 2;
  localparam int NL_FUND_BIT = 4;
  localparam int NL_STRIDE = 6;

  // interrupt status bits use the same layout as phase a
  localparam int IRQ_ACT = 0;
  localparam int IRQ_REACT = 1;
  localparam int IRQ_APP = 2;
  localparam int IRQ_FUND = 4;

  typedef enum logic [2:0] {
    SRC_IA = 3'h0,
    SRC_IB = 3'h1,
    SRC_IC = 3'h2,
    SRC_IN = 3'h3,
    SRC_VA = 3'h4,
    SRC_VB = 3'h5,
    SRC_VC = 3'h6,
    SRC_OWN = 3'h7
  } nlar_src_t;

  typedef struct packed {
    logic [2:0] active;
    logic [2:0] reactive;
    logic [2:0] apparent;
    logic [2:0] fund_reactive;
  } nlar_noload_t;

  typedef struct packed {
    logic [23:0] ia;
    logic [23:0] ib;
    logic [23:0] ic;
    logic [23:0] in_n;
    logic [23:0] va;
    logic [23:0] vb;
    logic [23:0] vc;
  } nlar_adc_set_t;

  function automatic logic [31:0] nlar_noload_word(input nlar_noload_t nl);
    logic [31:0] w;
    w = '0;
    for (int p = 0; p < PHASES; p++) begin
      w[NL_ACT_BIT + p * NL_STRIDE] = nl.active[p];
      w[NL_REACT_BIT + p * NL_STRIDE] = nl.reactive[p];
      w[NL_APP_BIT + p * NL_STRIDE] = nl.apparent[p];
      w[NL_FUND_BIT + p * NL_STRIDE] = nl.fund_reactive[p];
    end
    return w;
  endfunction

  function automatic logic [31:0] nlar_route_word(input logic [2:0] vb, input logic [2:0] vc);
    logic [31:0] w;
    w = '0;
    w[VB_LSB +: SEL_W] = vb;
    w[VC_LSB +: SEL_W] = vc;
    return w;
  endfunction

  function automatic logic [31:0] nlar_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < BYTES; b++) begin
      if (strb[b]) begin
        r[b * BYTE_W +: BYTE_W] = wd[b * BYTE_W +: BYTE_W];
      end
    end
    return r;
  endfunction

  function automatic logic [23:0] nlar_route(input logic [2:0] code, input nlar_adc_set_t s,
                                             input logic [23:0] own);
    logic [23:0] d;
    d = own;
    case (code)
      SRC_IA: d = s.ia;
      SRC_IB: d = s.ib;
      SRC_IC: d = s.ic;
      SRC_IN: d = s.in_n;
      SRC_VA: d = s.va;
      SRC_VB: d = s.vb;
      SRC_VC: d = s.vc;
      default: d = own;
    endcase
    return d;
  endfunction

endpackage

/* File: rtl/nlar_route_mux.sv */
`timescale 1ns/10ps
module nlar_route_mux
  import nlar_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [2:0] code_in,
  input wire nlar_adc_set_t adc_in,
  input wire logic [23:0] own_in,
  input wire logic valid_in,
  output logic [23:0] data_out,
  output logic valid_out
);
  logic [23:0] data_reg;
  logic valid_reg;
  wire logic [23:0] data_next = valid_in ? nlar_route(code_in, adc_in, own_in) : data_reg;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      data_reg <= data_next;
      valid_reg <= valid_in;
    end
  end

  assign data_out = data_reg;
  assign valid_out = valid_reg;
endmodule

/* File: rtl/nlar_irq.sv */
`timescale 1ns/10ps
module nlar_irq
  import nlar_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [31:0] event_in,
  input wire logic [31:0] clear_in,
  input wire logic mask_we_in,
  input wire logic [31:0] mask_in,
  output logic [31:0] status_out,
  output logic [31:0] mask_out,
  output logic irq_out
);
  logic [31:0] status_reg;
  logic [31:0] mask_reg;
  logic irq_reg;
  // set wins: a change in the clearing cycle stays pending
  wire logic [31:0] status_next = ((status_reg & ~clear_in) | event_in) & IRQ_IMPL;
  wire logic [31:0] mask_next = mask_we_in ? (mask_in & IRQ_IMPL) : mask_reg;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_reg <= '0;
      mask_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_next;
      irq_reg <= |(status_next & mask_next);
    end
  end

  assign status_out = status_reg;
  assign mask_out = mask_reg;
  assign irq_out = irq_reg;
endmodule

/* File: tb/nlar_host_model.sv */
`timescale 1ns/10ps
module nlar_host_model (
  input wire logic clk_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [15:0] paddr_out,
  output logic [31:0] pwdata_out,
  output logic [3:0] pstrb_out,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in
);
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 16'h0;
    pwdata_out = 32'h0;
    pstrb_out = 4'h0;
  end

  // starts on an edge of its own, so a release is never overwritten in one step
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= wr;
    paddr_out <= a;
    pwdata_out <= d;
    pstrb_out <= s;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    rd = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    // released address and write data lines show the inverse, not a stale copy
    paddr_out <= ~a;
    pwdata_out <= ~d;
  endtask
endmodule

/* File: tb/noload_status_and_adc_routing_tb.sv */
`timescale 1ns/10ps
module noload_status_and_adc_routing_tb
  import nlar_pkg::*;
();
  localparam int CYCLE_LIMIT = 3000;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  nlar_noload_t noload = '0;
  nlar_adc_set_t adc = '0;
  logic adc_valid = 1'b0;
  logic [23:0] volt_b, volt_c, level;
  logic volt_valid, irq;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  always #10 ref_clk = ~ref_clk;

  nlar_host_model host (.clk_in(ref_clk), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata), .pstrb_out(pstrb), .prdata_in(prdata), .pready_in(pready),
    .pslverr_in(pslverr));

  nlar_noload_regs dut (.ref_clk_in(ref_clk), .rst_in(rst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .noload_in(noload), .adc_in(adc),
    .adc_valid_in(adc_valid), .volt_b_data_out(volt_b), .volt_c_data_out(volt_c),
    .volt_data_valid_out(volt_valid), .fund_var_level_out(level), .irq_out(irq));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == CYCLE_LIMIT) begin
      failures++;
      stop_test();
    end
  end

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] v;
    logic e;
    host.xfer(1'b1, a, d, s, v, e);
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    logic e;
    host.xfer(1'b0, a, 32'h0, 4'h0, v, e);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic test_reset();
    logic [31:0] v;
    rd(ADDR_LEVEL, v);
    check(v, 32'h00045D45);
    check({8'h0, level}, 32'h00045D45);
    rd(ADDR_ROUTE, v);
    check(v, 32'h001F8000);
    rd(ADDR_NOLOAD, v);
    check(v, 32'h00000000);
    $display("test reset done");
  endtask

  task automatic test_level();
    logic [31:0] v;
    wr(ADDR_LEVEL, 32'hFFFFFFFF, 4'hF);
    rd(ADDR_LEVEL, v);
    check(v, 32'h00FFFFFF);
    wr(ADDR_LEVEL, 32'h5A5A5A12, 4'h1);
    rd(ADDR_LEVEL, v);
    check(v, 32'h00FFFF12);
    check({8'h0, level}, 32'h00FFFF12);
    $display("test level done");
  endtask

  task automatic test_noload();
    logic [31:0] v;
    int pos [4] = '{0, 1, 2, 4};
    for (int i = 0; i < 12; i++) begin
      @(posedge ref_clk);
      noload <= 12'h1 << (9 - 3 * (i / 3) + i % 3);
      rd(ADDR_NOLOAD, v);
      check(v, 32'h1 << (pos[i / 3] + 6 * (i % 3)));
    end
    wr(ADDR_NOLOAD, 32'hFFFFFFFF, 4'hF);
    rd(ADDR_NOLOAD, v);
    check(v, 32'h00010000);
    @(posedge ref_clk);
    noload <= 12'hFFF;
    rd(ADDR_NOLOAD, v);
    check(v, 32'h000175D7);
    $display("test noload done");
  endtask

  task automatic test_irq();
    logic [31:0] v;
    @(posedge ref_clk);
    noload <= '0;
    wr(ADDR_IRQ_STATUS, 32'hFFFFFFFF, 4'hF);
    rd(ADDR_IRQ_STATUS, v);
    check(v, 32'h0);
    wr(ADDR_IRQ_MASK, 32'hFFFFFFFF, 4'hF);
    rd(ADDR_IRQ_MASK, v);
    check(v, 32'h00000017);
    @(posedge ref_clk);
    noload <= 12'h400;
    settle(2);
    check({31'h0, irq}, 32'h1);
    rd(ADDR_IRQ_STATUS, v);
    check(v, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h1, 4'hF);
    settle(2);
    check({31'h0, irq}, 32'h0);
    // leaving no-load is an event too; masked it must stay quiet
    wr(ADDR_IRQ_MASK, 32'h0, 4'hF);
    @(posedge ref_clk);
    noload <= '0;
    settle(2);
    check({31'h0, irq}, 32'h0);
    rd(ADDR_IRQ_STATUS, v);
    check(v, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h1, 4'hF);
    wr(ADDR_IRQ_MASK, 32'h17, 4'hF);
    @(posedge ref_clk);
    noload <= 12'h049;
    settle(2);
    check({31'h0, irq}, 32'h1);
    rd(ADDR_IRQ_STATUS, v);
    check(v, 32'h16);
    wr(ADDR_IRQ_STATUS, 32'h16, 4'hF);
    rd(ADDR_IRQ_STATUS, v);
    check(v, 32'h0);
    $display("test irq done");
  endtask

  task automatic test_route();
    logic [31:0] v;
    logic [23:0] s [7];
    int b;
    for (int k = 0; k < 7; k++) begin
      s[k] = 24'h111111 * (k + 1);
    end
    @(posedge ref_clk);
    adc <= '{ia: s[0], ib: s[1], ic: s[2], in_n: s[3], va: s[4], vb: s[5], vc: s[6]};
    for (int c = 0; c < 8; c++) begin
      b = 7 - c;
      wr(ADDR_ROUTE, {11'h7FF, c[2:0], b[2:0], 15'h7FFF}, 4'hF);
      rd(ADDR_ROUTE, v);
      check(v, {11'h0, c[2:0], b[2:0], 15'h0});
      @(posedge ref_clk);
      adc_valid <= 1'b1;
      @(posedge ref_clk);
      adc_valid <= 1'b0;
      #1;
      check({31'h0, volt_valid}, 32'h1);
      check({8'h0, volt_c}, {8'h0, (c == 7) ? s[6] : s[c]});
      check({8'h0, volt_b}, {8'h0, (b == 7) ? s[5] : s[b]});
      settle(1);
      check({31'h0, volt_valid}, 32'h0);
    end
    $display("test route done");
  endtask

  task automatic test_unmapped();
    logic [31:0] v;
    logic e;
    host.xfer(1'b0, 16'h0000, 32'h0, 4'h0, v, e);
    check(v, 32'h0);
    check({31'h0, e}, 32'h1);
    // neighbour of the level word must not alias onto it
    host.xfer(1'b1, 16'h1038, 32'hFFFFFFFF, 4'hF, v, e);
    check({31'h0, e}, 32'h1);
    rd(ADDR_LEVEL, v);
    check(v, 32'h00FFFF12);
    $display("test unmapped done");
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    test_reset();
    test_level();
    test_noload();
    test_irq();
    test_route();
    test_unmapped();
    stop_test();
  end
endmodule
